// [bench/slce_monitor.sv]
// Purpose: port checks of the axis block
// Assumes: one pclk domain, presetn async active low
// Notes:   bound to slce_axis after the module
`include "slce_consts.svh"
module slce_monitor #(
  parameter int unsigned PD_UNIT_CYC = 4,  // cycles per delay unit
  parameter int unsigned LOAD_W      = 10  // load width
) (
  input wire logic        pclk,          // clock
  input wire logic        presetn,       // async reset, active low
  input wire logic        psel,          // apb select
  input wire logic        penable,       // apb enable
  input wire logic        pwrite,        // apb direction
  input wire logic [11:0] paddr,         // apb address
  input wire logic [31:0] motor_speed,   // actual speed
  input wire logic        motor_moving,  // moving level
  input wire logic        load_valid,    // load reading strobe
  input wire logic [4:0]  coil_current,  // current step
  input wire logic        standby,       // standby level
  input wire logic        unit_mode,     // unit mode
  input wire logic [3:0]  microstep      // microstep code
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // helpers
  logic wr;  // write access phase
  logic run; // stable run current conditions
  assign wr  = psel && penable && pwrite;
  assign run = !standby && motor_moving;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // assertions
  a_unit_write: assert property ($changed(unit_mode) |->
    $past(wr && paddr == `SLCE_OFF_CTRL)) else $error("unit mode moved without write");
  a_ustep_write: assert property ($changed(microstep) |->
    $past(wr && paddr == `SLCE_OFF_MICROSTEP)) else $error("microstep moved without write");
  a_ustep_range: assert property (microstep <= 4'h8)
    else $error("microstep code above 8");
  a_stby_entry: assert property ($rose(standby) |->
    !motor_moving && $past(!motor_moving) && $past(!motor_moving, 2))
    else $error("standby without standstill");
  a_stby_leave: assert property (motor_moving && $past(motor_moving)
    && $past(motor_moving, 2) |-> !standby) else $error("standby while moving");
  a_cur_down: assert property (run && $past(run) && !$past(wr)
    && !$past(wr, 2) && coil_current < $past(coil_current) |-> $past(load_valid)
    && coil_current == $past(coil_current) - 5'h01) else $error("bad current decrement");
  a_cur_up: assert property (run && $past(run) && !$past(wr) && !$past(wr, 2)
    && motor_speed == $past(motor_speed, 2) && coil_current > $past(coil_current)
    |-> $past(load_valid)) else $error("current rose without reading");
  a_still_nodrop: assert property (!motor_moving && $past(!motor_moving)
    && !standby && !$past(standby) && !$past(wr) && !$past(wr, 2)
    |-> coil_current >= $past(coil_current))
    else $error("current lowered at standstill");
endmodule : slce_monitor

bind slce_axis slce_monitor #(.PD_UNIT_CYC(PD_UNIT_CYC), .LOAD_W(LOAD_W)) slce_monitor_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .motor_speed, .motor_moving,
  .load_valid, .coil_current, .standby, .unit_mode, .microstep);

// [bench/slce_motor_model.sv]
// Purpose: motor with incremental encoder at the far side
// Assumes: 256 microsteps per encoder count
// Notes:   slip holds the encoder while the counter runs on
module slce_motor_model (
  input  wire logic        pclk,         // clock
  input  wire logic        presetn,      // async reset, active low
  input  wire logic        go,           // move command
  input  wire logic        slip,         // rotor blocked
  output logic             enc_a,        // quadrature a
  output logic             enc_b,        // quadrature b
  output logic      [31:0] motor_pos,    // microstep counter
  output logic             motor_moving  // moving level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;  // quadrature phase
  logic [1:0] div; // one count per four cycles
  // step generator, encoder follows unless blocked
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ph <= 2'h0;
      div <= 2'h0;
      motor_pos <= 32'h0;
    end
    else if (go)
    begin
      div <= div + 2'h1;
      if (div == 2'h3)
      begin
        motor_pos <= motor_pos + 32'h100;
        if (!slip)
          ph <= ph + 2'h1;
      end
    end
  // gray order 00, 01, 11, 10 counts up
  assign enc_a = ph[1];
  assign enc_b = ph[1] ^ ph[0];
  assign motor_moving = go;
endmodule : slce_motor_model

// [bench/tb_top.sv]
// Purpose: self-checking bench of the axis block
// Assumes: zero-wait apb slave, shortened delay unit
// Notes:   random values from a fixed seed
`include "slce_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic go = 0, slip = 0, enc_null = 0, ref_done = 0, load_valid = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, motor_speed = 0, prdata, motor_pos;
  logic [9:0]  load_value = 0;
  logic        pready, pslverr, enc_a, enc_b, motor_moving, stop_req;
  logic        standby, unit_mode, irq;
  logic [4:0]  coil_current;
  logic [3:0]  microstep;
  int fails = 0, n_checks = 0;
  always #5 pclk = ~pclk;
  slce_motor_model slce_motor_model_inst (.pclk, .presetn, .go, .slip, .enc_a, .enc_b,
    .motor_pos, .motor_moving);
  slce_axis #(.PD_UNIT_CYC(4)) slce_axis_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .enc_a, .enc_b, .enc_null, .motor_pos,
    .motor_speed, .motor_moving, .ref_done, .load_value, .load_valid, .stop_req,
    .coil_current, .standby, .unit_mode, .microstep, .irq);
  // ==========================================================
  // verdict and compare
  task automatic print_verdict;
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex)
    begin
      fails++;
      $display("FAIL %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  // ==========================================================
  // apb master and readings
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ex);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk($sformatf("reg_%h", a), ex, q & m);
  endtask : rd
  task automatic load(input logic [9:0] v);
    @(posedge pclk);
    load_value <= v;
    load_valid <= 1'b1;
    @(posedge pclk);
    load_valid <= 1'b0;
  endtask : load
  task automatic pulse_in(input int which);
    @(posedge pclk);
    if (which == 0) ref_done <= 1'b1; else enc_null <= 1'b1;
    @(posedge pclk);
    ref_done <= 1'b0;
    enc_null <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask : pulse_in
  // expected step after one low reading, saturated at the scale
  function automatic logic [31:0] up_exp(input int f, input int u);
    return (f + (1 << u) > 31) ? 32'd31 : f + (1 << u);
  endfunction : up_exp
  // ==========================================================
  // watchdog
  initial
  begin
    repeat (40000) @(posedge pclk);
    fails++;
    print_verdict;
  end
  // ==========================================================
  // main sequence
  initial
  begin
    int n, k, f;
    logic [31:0] v, q;
    logic e;
    v = $urandom(42);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("coil", 31, coil_current);
    chk("unit", 1, unit_mode);
    chk("ustep", 8, microstep);
    chk("irq", 0, irq);
    rd(`SLCE_OFF_FULLSTEP, '1, 200);
    rd(`SLCE_OFF_PD_DELAY, '1, 200);
    rd(`SLCE_OFF_RUN_CUR, '1, 255);
    apb(1'b0, 12'h03c, 32'h0, q, e);
    chk("unmapped_err", 1, e);
    wr(`SLCE_OFF_CTRL, 0);
    chk("unit", 0, unit_mode);
    wr(`SLCE_OFF_MICROSTEP, 4);
    chk("ustep", 4, microstep);
    wr(`SLCE_OFF_MICROSTEP, 9);
    chk("ustep", 8, microstep);
    // encoder follows the counter
    n = 1 + $urandom % 8;
    go <= 1'b1;
    repeat (4 * n) @(posedge pclk);
    go <= 1'b0;
    repeat (3) @(negedge pclk);
    rd(`SLCE_OFF_ENC_POS, '1, n * ((200 << 8) / 200));
    v = $urandom;
    wr(`SLCE_OFF_ENC_POS, v);
    rd(`SLCE_OFF_ENC_POS, '1, v);
    pulse_in(0);
    rd(`SLCE_OFF_ENC_POS, '1, 0);
    wr(`SLCE_OFF_ENC_POS, v);
    wr(`SLCE_OFF_CTRL, 5);
    pulse_in(1);
    rd(`SLCE_OFF_ENC_POS, '1, 0);
    // deviation stop
    wr(`SLCE_OFF_DEV_LIMIT, 100);
    wr(`SLCE_OFF_ENC_POS, motor_pos);
    wr(`SLCE_OFF_CTRL, 3);
    slip <= 1'b1;
    go <= 1'b1;
    repeat (4) @(posedge pclk);
    go <= 1'b0;
    slip <= 1'b0;
    for (k = 0; k < 8 && stop_req !== 1'b1; k++) @(negedge pclk);
    chk("dev_stop", 1, stop_req);
    wr(`SLCE_OFF_CTRL, 1);
    // stall stop and interrupt
    wr(`SLCE_OFF_STALL_SPD, 50);
    wr(`SLCE_OFF_IRQ_MASK, 1);
    motor_speed <= 40;
    load(0);
    @(negedge pclk);
    chk("stall_slow", 0, stop_req);
    motor_speed <= 100;
    load(0);
    @(negedge pclk);
    chk("stall_stop", 1, stop_req);
    chk("irq", 1, irq);
    rd(`SLCE_OFF_IRQ_STAT, '1, 15);
    wr(`SLCE_OFF_IRQ_STAT, 15);
    chk("irq", 0, irq);
    // adaptive current down steps and band
    wr(`SLCE_OFF_ADAPT_SPD, 10);
    for (int d = 0; d < 4; d++)
    begin
      wr(`SLCE_OFF_ADAPT, (100 << 16) | (10 << 8) | (d << 1));
      go <= 1'b1;
      repeat (d == 0 ? 32 : d == 1 ? 8 : d == 2 ? 2 : 1) load(500);
      rd(`SLCE_OFF_STATUS, 31, 30);
      load(105);
      rd(`SLCE_OFF_STATUS, 31, 30);
      go <= 1'b0;
    end
    // floor, up steps and top saturation
    for (int i = 0; i < 8; i++)
    begin
      wr(`SLCE_OFF_ADAPT, (100 << 16) | (10 << 8) | ((i % 4) << 3) | (3 << 1) | (i / 4));
      go <= 1'b1;
      load(50);
      rd(`SLCE_OFF_STATUS, 31, 31);
      repeat (30) load(500);
      f = 31 >> (i / 4 + 1);
      rd(`SLCE_OFF_STATUS, 31, f);
      load(50);
      rd(`SLCE_OFF_STATUS, 31, up_exp(f, i % 4));
      go <= 1'b0;
    end
    // below threshold speed nothing regulates
    @(posedge pclk);
    motor_speed <= 5;
    go <= 1'b1;
    repeat (4) load(500);
    rd(`SLCE_OFF_STATUS, 31, 31);
    v = $urandom;
    wr(`SLCE_OFF_RUN_CUR, v);
    @(negedge pclk);
    chk("coil_run", v[7:3], coil_current);
    // standby after the power down delay
    q = $urandom;
    wr(`SLCE_OFF_STBY_CUR, q);
    wr(`SLCE_OFF_PD_DELAY, 2);
    go <= 1'b0;
    repeat (6) @(negedge pclk);
    chk("standby_early", 0, standby);
    for (k = 0; k < 12 && standby !== 1'b1; k++) @(negedge pclk);
    chk("standby", 1, standby);
    chk("coil_stby", q[7:3], coil_current);
    print_verdict;
  end
endmodule : tb_top

// [common/slce_consts.svh]
// Purpose: offsets, field positions, reset values and timing counts of the axis block
// Assumes: 32-bit APB, one register per aligned word
// Notes:   included by the package and by the design
`ifndef SLCE_CONSTS_SVH
`define SLCE_CONSTS_SVH
// ==========================================================
// register byte offsets
`define SLCE_OFF_CTRL        12'h000
`define SLCE_OFF_FULLSTEP    12'h004
`define SLCE_OFF_ENC_CPR     12'h008
`define SLCE_OFF_ENC_POS     12'h00c
`define SLCE_OFF_MICROSTEP   12'h010
`define SLCE_OFF_RUN_CUR     12'h014
`define SLCE_OFF_STBY_CUR    12'h018
`define SLCE_OFF_PD_DELAY    12'h01c
`define SLCE_OFF_ADAPT       12'h020
`define SLCE_OFF_STALL_SPD   12'h024
`define SLCE_OFF_ADAPT_SPD   12'h028
`define SLCE_OFF_DEV_LIMIT   12'h02c
`define SLCE_OFF_STATUS      12'h030
`define SLCE_OFF_IRQ_STAT    12'h034
`define SLCE_OFF_IRQ_MASK    12'h038
// ==========================================================
// control bit positions
`define SLCE_CTRL_UNIT       0
`define SLCE_CTRL_DEV_STOP   1
`define SLCE_CTRL_NULL_CLR   2
// adaptive config fields
`define SLCE_AD_MIN          0
`define SLCE_AD_DOWN_LO      1
`define SLCE_AD_UP_LO        3
`define SLCE_AD_HYST_LO      8
`define SLCE_AD_LOWER_LO     16
// interrupt bits
`define SLCE_IRQ_STALL       0
`define SLCE_IRQ_DEVIATION   1
`define SLCE_IRQ_NULL        2
`define SLCE_IRQ_REF         3
// ==========================================================
// reset values
`define SLCE_RST_CTRL        32'h0000_0001
`define SLCE_RST_FULLSTEP    16'h00c8
`define SLCE_RST_ENC_CPR     16'h00c8
`define SLCE_RST_MICROSTEP   4'h8
`define SLCE_RST_RUN_CUR     8'hff
`define SLCE_RST_STBY_CUR    8'h00
`define SLCE_RST_PD_DELAY    16'h00c8
`define SLCE_RST_ADAPT       32'h0000_0000
// ==========================================================
// timing: delay unit and clock
`define SLCE_PD_UNIT_NS      10000000
`define SLCE_CLK_NS          10
`define SLCE_PD_UNIT_CYC     (`SLCE_PD_UNIT_NS / `SLCE_CLK_NS)
`endif

// [common/slce_pkg.sv]
// Purpose: types of the axis block
// Assumes: constants come from slce_consts.svh
// Notes:   whole state of the block is one packed struct
`include "slce_consts.svh"
package slce_pkg;
  // ==========================================================
  // complete registered state
  typedef struct packed {
    logic [31:0] ctrl;        // unit mode, deviation stop, null clear
    logic [15:0] fullstep;    // motor full steps per revolution
    logic [15:0] enc_cpr;     // encoder counts per revolution
    logic [31:0] enc_pos;     // scaled encoder position
    logic [15:0] enc_frac;    // scaling remainder
    logic [3:0]  microstep;   // microstep code, 2**code per full step
    logic [7:0]  run_cur;     // absolute max run current
    logic [7:0]  stby_cur;    // standby current
    logic [15:0] pd_delay;    // power down delay, 10 ms units
    logic [31:0] adapt;       // adaptive current configuration
    logic [31:0] stall_spd;   // stall stop speed
    logic [31:0] adapt_spd;   // adaptive current speed threshold
    logic [31:0] dev_limit;   // allowed encoder deviation
    logic [3:0]  irq_stat;    // sticky events
    logic [3:0]  irq_mask;    // event enables
    logic [1:0]  enc_ab;      // last quadrature sample
    logic        enc_n;       // last index sample
    logic [4:0]  cur;         // regulated current step
    logic [4:0]  down_cnt;    // readings above the upper threshold
    logic [23:0] tick_cnt;    // 10 ms tick divider
    logic [15:0] pd_cnt;      // elapsed standstill ticks
    logic        standby;     // standby current active
    logic        stop_req;    // stop request pulse
    logic [31:0] prdata;      // read data
    logic        pslverr;     // unmapped access
  } slce_state_s;
endpackage : slce_pkg

// [verilog/slce_axis.sv]
// Purpose: encoder scaling, stall stop, load-adaptive and standby current for one axis
// Assumes: all inputs synchronous to pclk; speeds in the same unit as the thresholds
// Notes:   APB slave, zero wait states; one level interrupt
//
// How it works
// - encoder counts scaled to motor microsteps
// - full steps per revolution default 200
// - encoder position writable, cleared on reference
// - deviation stop when encoder stops following
// - function bit clears position on index
// - load value falls to zero at maximum load
// - stall stop only above stall speed
// - adaptive current only above threshold speed
// - run current 0..255 in 32 steps
// - standby current after power down delay
// - minimum current half or quarter of scale
// - decrement per 32, 8, 2, 1 readings
// - increment by 1, 2, 4, 8 below lower
// - hysteresis spaces the two thresholds
// - unit mode 1 pps, 0 internal units
// - microstep code 8 means 256, default
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`include "slce_consts.svh"
module slce_axis #(
  parameter int unsigned PD_UNIT_CYC = `SLCE_PD_UNIT_CYC, // cycles per 10 ms delay unit
  parameter int unsigned LOAD_W      = 10                 // load measurement width
) (
  input  wire logic              pclk,          // clock, 100 MHz
  input  wire logic              presetn,       // async reset, active low
  input  wire logic              psel,          // apb select
  input  wire logic              penable,       // apb enable
  input  wire logic              pwrite,        // apb direction
  input  wire logic [11:0]       paddr,         // apb byte address
  input  wire logic [31:0]       pwdata,        // apb write data
  output logic      [31:0]       prdata,        // apb read data
  output logic                   pready,        // apb ready
  output logic                   pslverr,       // apb error
  input  wire logic              enc_a,         // encoder channel a
  input  wire logic              enc_b,         // encoder channel b
  input  wire logic              enc_null,      // encoder index channel
  input  wire logic [31:0]       motor_pos,     // microstep position counter
  input  wire logic [31:0]       motor_speed,   // absolute actual speed
  input  wire logic              motor_moving,  // ramp not at standstill
  input  wire logic              ref_done,      // reference search finished, pulse
  input  wire logic [LOAD_W-1:0] load_value,    // sensorless load measurement
  input  wire logic              load_valid,    // new load reading, pulse
  output logic                   stop_req,      // stop the motor, pulse
  output logic      [4:0]        coil_current,  // current step to the driver
  output logic                   standby,       // standby current in use
  output logic                   unit_mode,     // 1 pps units, 0 internal
  output logic      [3:0]        microstep,     // microstep code to the driver
  output logic                   irq            // interrupt, level
);

  // ==========================================================
  // helpers
  // quantise an 8-bit current into one of 32 steps
  function automatic logic [4:0] cur_step(input logic [7:0] c);
    cur_step = c[7:3];
  endfunction : cur_step

  // saturating add on a 5-bit current step, capped at hi
  function automatic logic [4:0] sat_add(input logic [4:0] a, input logic [4:0] b,
                                         input logic [4:0] hi);
    logic [5:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = (s > {1'b0, hi}) ? hi : s[4:0];
  endfunction : sat_add

  slce_pkg::slce_state_s q;      // registered state
  slce_pkg::slce_state_s next_q; // next state

  // ==========================================================
  // derived values
  logic        setup;        // apb setup phase
  logic        wr;           // write taken this edge
  logic [1:0]  ab_now;       // current quadrature sample
  logic        cnt_up;       // one count forward
  logic        cnt_dn;       // one count backward
  logic [16:0] steps_rev;    // microsteps per revolution
  logic [16:0] scale_q;      // whole microsteps per encoder count
  logic [15:0] scale_r;      // remainder per encoder count
  logic [16:0] frac_sum;     // remainder accumulation
  logic        frac_carry;   // remainder overflowed
  logic [31:0] move;         // microsteps to add this cycle
  logic [31:0] diff;         // motor minus encoder
  logic [31:0] adiff;        // absolute deviation
  logic        dev_hit;      // deviation beyond limit
  logic        stall_hit;    // stall condition met
  logic [4:0]  cs;           // current scale
  logic [4:0]  cmin;         // lowest adaptive current
  logic [LOAD_W:0] lower;    // lower load threshold
  logic [LOAD_W:0] upper;    // upper load threshold
  logic [4:0]  down_need;    // readings counted before a decrement
  logic [4:0]  up_size;      // increment size
  logic        adapt_on;     // adaptive regulation enabled
  logic [3:0]  events;       // events this cycle
  logic [31:0] rd;           // read mux
  logic        hit;          // mapped address

  // ==========================================================
  // combinational decode
  always_comb
  begin
    setup  = psel & ~penable;
    wr     = psel & penable & pwrite & ~q.pslverr;
    ab_now = {enc_a, enc_b};
    // gray sequence 00 01 11 10 counts forward
    cnt_up = (q.enc_ab == 2'b00 && ab_now == 2'b01) || (q.enc_ab == 2'b01 && ab_now == 2'b11)
          || (q.enc_ab == 2'b11 && ab_now == 2'b10) || (q.enc_ab == 2'b10 && ab_now == 2'b00);
    cnt_dn = (q.enc_ab == 2'b01 && ab_now == 2'b00) || (q.enc_ab == 2'b11 && ab_now == 2'b01)
          || (q.enc_ab == 2'b10 && ab_now == 2'b11) || (q.enc_ab == 2'b00 && ab_now == 2'b10);
    // microsteps per revolution over counts per revolution
    steps_rev  = 17'(({1'b0, q.fullstep} << q.microstep[3:0]));
    scale_q    = (q.enc_cpr == 16'h0000) ? 17'h00000 : steps_rev / {1'b0, q.enc_cpr};
    scale_r    = (q.enc_cpr == 16'h0000) ? 16'h0000 : 16'(steps_rev % {1'b0, q.enc_cpr});
    frac_sum   = {1'b0, q.enc_frac} + {1'b0, scale_r};
    frac_carry = (frac_sum >= {1'b0, q.enc_cpr}) && (q.enc_cpr != 16'h0000);
    move       = 32'(scale_q) + (frac_carry ? 32'h0000_0001 : 32'h0000_0000);
    // deviation supervision
    diff    = motor_pos - q.enc_pos;
    adiff   = diff[31] ? (32'h0000_0000 - diff) : diff;
    dev_hit = q.ctrl[`SLCE_CTRL_DEV_STOP] && (adiff > q.dev_limit);
    // zero load reading means maximum load
    stall_hit = load_valid && (load_value == '0) && (q.stall_spd != 32'h0000_0000)
             && (motor_speed > q.stall_spd);
    // adaptive current limits
    cs   = cur_step(q.run_cur);
    cmin = q.adapt[`SLCE_AD_MIN] ? (cs >> 2) : (cs >> 1);
    // thresholds spaced by the hysteresis
    lower = (LOAD_W+1)'(q.adapt[`SLCE_AD_LOWER_LO +: 10]);
    upper = lower + (LOAD_W+1)'(q.adapt[`SLCE_AD_HYST_LO +: 5]);
    unique case (q.adapt[`SLCE_AD_DOWN_LO +: 2])
      2'd0: down_need = 5'h1f;
      2'd1: down_need = 5'h07;
      2'd2: down_need = 5'h01;
      2'd3: down_need = 5'h00;
    endcase
    up_size  = 5'h01 << q.adapt[`SLCE_AD_UP_LO +: 2];
    adapt_on = motor_moving && (motor_speed > q.adapt_spd);
    // events: stall, deviation, index clear, reference clear
    events = 4'h0;
    events[`SLCE_IRQ_STALL]     = stall_hit;
    events[`SLCE_IRQ_DEVIATION] = dev_hit;
    events[`SLCE_IRQ_NULL]      = enc_null & ~q.enc_n & q.ctrl[`SLCE_CTRL_NULL_CLR];
    events[`SLCE_IRQ_REF]       = ref_done;
  end

  // ==========================================================
  // register read mux
  always_comb
  begin
    rd  = 32'h0000_0000;
    hit = 1'b1;
    unique case (paddr)
      `SLCE_OFF_CTRL:      rd = q.ctrl & 32'h0000_0007;
      `SLCE_OFF_FULLSTEP:  rd = {16'h0000, q.fullstep};
      `SLCE_OFF_ENC_CPR:   rd = {16'h0000, q.enc_cpr};
      `SLCE_OFF_ENC_POS:   rd = q.enc_pos;
      `SLCE_OFF_MICROSTEP: rd = {28'h000_0000, q.microstep};
      `SLCE_OFF_RUN_CUR:   rd = {24'h00_0000, q.run_cur};
      `SLCE_OFF_STBY_CUR:  rd = {24'h00_0000, q.stby_cur};
      `SLCE_OFF_PD_DELAY:  rd = {16'h0000, q.pd_delay};
      `SLCE_OFF_ADAPT:     rd = q.adapt & 32'h03ff_1f1f;
      `SLCE_OFF_STALL_SPD: rd = q.stall_spd;
      `SLCE_OFF_ADAPT_SPD: rd = q.adapt_spd;
      `SLCE_OFF_DEV_LIMIT: rd = q.dev_limit;
      `SLCE_OFF_STATUS:    rd = {16'h0000, 5'h00, q.down_cnt, q.standby, q.cur};
      `SLCE_OFF_IRQ_STAT:  rd = {28'h000_0000, q.irq_stat};
      `SLCE_OFF_IRQ_MASK:  rd = {28'h000_0000, q.irq_mask};
      default:             hit = 1'b0; // unmapped: error, zero data
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_q          = q;
    next_q.stop_req = 1'b0;
    next_q.enc_ab   = ab_now;
    next_q.enc_n    = enc_null;
    // apb: latch read data and error at setup
    if (setup)
    begin
      next_q.prdata  = (hit && !pwrite) ? rd : 32'h0000_0000;
      next_q.pslverr = ~hit;
    end
    // encoder scaling
    if (cnt_up)
    begin
      next_q.enc_pos  = q.enc_pos + move;
      next_q.enc_frac = frac_carry ? 16'(frac_sum - {1'b0, q.enc_cpr}) : frac_sum[15:0];
    end
    else if (cnt_dn)
    begin
      next_q.enc_pos  = q.enc_pos - move;
      next_q.enc_frac = frac_carry ? 16'(frac_sum - {1'b0, q.enc_cpr}) : frac_sum[15:0];
    end
    // index and reference clear win over counting
    if (events[`SLCE_IRQ_NULL] || ref_done)
    begin
      next_q.enc_pos  = 32'h0000_0000;
      next_q.enc_frac = 16'h0000;
    end
    // stop on stall or deviation
    if (stall_hit || dev_hit)
      next_q.stop_req = 1'b1;
    // standstill timer in 10 ms ticks
    if (motor_moving)
    begin
      next_q.tick_cnt = 24'h00_0000;
      next_q.pd_cnt   = 16'h0000;
      next_q.standby  = 1'b0;
    end
    else if (!q.standby)
    begin
      if (q.pd_cnt >= q.pd_delay)
        next_q.standby = 1'b1;
      else if (q.tick_cnt == 24'(PD_UNIT_CYC - 1))
      begin
        next_q.tick_cnt = 24'h00_0000;
        next_q.pd_cnt   = q.pd_cnt + 16'h0001;
      end
      else
        next_q.tick_cnt = q.tick_cnt + 24'h00_0001;
    end
    // current regulation
    if (!adapt_on)
    begin
      next_q.cur      = cs; // full scale outside the adaptive range
      next_q.down_cnt = 5'h00;
    end
    else if (load_valid)
    begin
      if ((LOAD_W+1)'(load_value) < lower)
      begin
        next_q.cur      = sat_add(q.cur, up_size, cs);
        next_q.down_cnt = 5'h00;
      end
      else if ((LOAD_W+1)'(load_value) > upper)
      begin
        if (q.down_cnt >= down_need)
        begin
          next_q.down_cnt = 5'h00;
          next_q.cur      = (q.cur > cmin) ? q.cur - 5'h01 : cmin;
        end
        else
          next_q.down_cnt = q.down_cnt + 5'h01;
      end
    end
    // register writes, taken in the access cycle
    if (wr)
    begin
      unique case (paddr)
        `SLCE_OFF_CTRL:      next_q.ctrl      = pwdata & 32'h0000_0007;
        `SLCE_OFF_FULLSTEP:  next_q.fullstep  = pwdata[15:0];
        `SLCE_OFF_ENC_CPR:   next_q.enc_cpr   = pwdata[15:0];
        `SLCE_OFF_ENC_POS:
        begin
          next_q.enc_pos  = pwdata;
          next_q.enc_frac = 16'h0000;
        end
        `SLCE_OFF_MICROSTEP: next_q.microstep = (pwdata[3:0] > 4'h8) ? 4'h8 : pwdata[3:0];
        `SLCE_OFF_RUN_CUR:   next_q.run_cur   = pwdata[7:0];
        `SLCE_OFF_STBY_CUR:  next_q.stby_cur  = pwdata[7:0];
        `SLCE_OFF_PD_DELAY:  next_q.pd_delay  = pwdata[15:0];
        `SLCE_OFF_ADAPT:     next_q.adapt     = pwdata & 32'h03ff_1f1f;
        `SLCE_OFF_STALL_SPD: next_q.stall_spd = pwdata;
        `SLCE_OFF_ADAPT_SPD: next_q.adapt_spd = pwdata;
        `SLCE_OFF_DEV_LIMIT: next_q.dev_limit = pwdata;
        `SLCE_OFF_IRQ_STAT:  next_q.irq_stat  = q.irq_stat & ~pwdata[3:0]; // write one clears
        `SLCE_OFF_IRQ_MASK:  next_q.irq_mask  = pwdata[3:0];
        default:             ; // read-only status
      endcase
    end
    // new events win over a clear in the same cycle
    next_q.irq_stat = next_q.irq_stat | events;
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q           <= '0;
      q.ctrl      <= `SLCE_RST_CTRL;
      q.fullstep  <= `SLCE_RST_FULLSTEP;
      q.enc_cpr   <= `SLCE_RST_ENC_CPR;
      q.microstep <= `SLCE_RST_MICROSTEP;
      q.run_cur   <= `SLCE_RST_RUN_CUR;
      q.stby_cur  <= `SLCE_RST_STBY_CUR;
      q.pd_delay  <= `SLCE_RST_PD_DELAY;
      q.adapt     <= `SLCE_RST_ADAPT;
      q.cur       <= 5'h1f;
    end
    else
      q <= next_q;
  end

  // ==========================================================
  // outputs
  always_comb
  begin
    prdata       = q.prdata;
    pready       = 1'b1; // zero wait states
    pslverr      = psel & penable & q.pslverr;
    stop_req     = q.stop_req;
    coil_current = q.standby ? cur_step(q.stby_cur) : q.cur;
    standby      = q.standby;
    unit_mode    = q.ctrl[`SLCE_CTRL_UNIT];
    microstep    = q.microstep;
    irq          = |(q.irq_stat & q.irq_mask);
  end

endmodule : slce_axis
